// *** core/scss_map.svh ***
`ifndef SCSS_MAP_SVH
`define SCSS_MAP_SVH

// register byte offsets
`define SCSS_OFS_CTRL      8'h00
`define SCSS_OFS_STATUS    8'h04

// control register fields
`define SCSS_CTRL_SEL_LSB  0
`define SCSS_CTRL_SEL_MSB  1
`define SCSS_CTRL_LF_BIT   2
`define SCSS_CTRL_RESET    3'h0

// status register fields
`define SCSS_ST_SRC_LSB    0
`define SCSS_ST_SRC_MSB    1
`define SCSS_ST_BUSY_BIT   2
`define SCSS_ST_STW_BIT    3
`define SCSS_ST_GAIN_LSB   4
`define SCSS_ST_GAIN_MSB   5
`define SCSS_ST_PWR_LSB    6
`define SCSS_ST_PWR_MSB    7
`define SCSS_ST_CKO_BIT    8
`define SCSS_ST_CFG_LSB    9
`define SCSS_ST_CFG_MSB    11

// clock_source_config codes
`define SCSS_CFG_XTAL_LO    3'h0
`define SCSS_CFG_XTAL_MID   3'h1
`define SCSS_CFG_XTAL_HI    3'h2
`define SCSS_CFG_RC         3'h3
`define SCSS_CFG_INTOSC     3'h4
`define SCSS_CFG_LOGIC_LOW  3'h5
`define SCSS_CFG_LOGIC_MED  3'h6
`define SCSS_CFG_LOGIC_HIGH 3'h7

// system_clock_select codes
`define SCSS_SEL_CONFIG    2'h0
`define SCSS_SEL_SECOND    2'h1

// amplifier gain and external power range codes
`define SCSS_LVL_OFF       2'h0
`define SCSS_LVL_LOW       2'h1
`define SCSS_LVL_MED       2'h2
`define SCSS_LVL_HIGH      2'h3

// internal oscillator rates
`define SCSS_HF_INT_HZ     16000000
`define SCSS_LF_INT_HZ     31000

// start-up timer length in oscillator edges
`define SCSS_STARTUP_EDGES 1024

// axi response codes
`define SCSS_RESP_OKAY     2'h0
`define SCSS_RESP_SLVERR   2'h2

`endif

// *** core/scss_pkg.sv ***
package scss_pkg;

	// switch sequencer states
	typedef enum logic [1:0] {
		SW_BOOT = 2'b00,
		SW_RUN  = 2'b01,
		SW_PARK = 2'b10,
		SW_WAIT = 2'b11
	} scss_sw_t;

	// system clock origins
	typedef enum logic [1:0] {
		SRC_EXT  = 2'b00,
		SRC_SOSC = 2'b01,
		SRC_HF   = 2'b10,
		SRC_LF   = 2'b11
	} scss_src_t;

endpackage : scss_pkg

// *** core/scss_ost.sv ***
`timescale 1ns/1ps
`include "scss_map.svh"

module scss_startup #(
	parameter int EDGES = `SCSS_STARTUP_EDGES
) (
	input  wire logic aclk,     // system clock
	input  wire logic aresetn,  // sync reset, active low
	input  wire logic osc_lvl,  // external oscillator level
	input  wire logic restart,  // pulse: begin a new start-up count
	input  wire logic bypass,   // no start-up wait in this mode
	output logic      ready     // oscillator deemed stable
);
	localparam int CW = $clog2(EDGES + 1);

	initial begin
		if (EDGES < 1)
			$error("scss_startup: EDGES must be at least 1");
	end

	typedef struct packed {
		logic          prev;
		logic [CW-1:0] cnt;
		logic          done;
	} scss_startup_st_t;

	scss_startup_st_t st_r;
	scss_startup_st_t st_nxt;

	// count rising edges of the oscillator until the stable mark
	always_comb begin
		st_nxt      = st_r;
		st_nxt.prev = osc_lvl;
		if (restart) begin
			st_nxt.cnt  = '0;
			st_nxt.done = 1'b0;
		end else if (!st_r.done && osc_lvl && !st_r.prev) begin
			st_nxt.cnt = st_r.cnt + CW'(1);
			if (st_r.cnt == CW'(EDGES - 1))
				st_nxt.done = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	// bypass skips the wait altogether
	assign ready = st_r.done || bypass;

	a_startup_count: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(st_r.done) |-> $past(st_r.cnt) == CW'(EDGES - 1))
		else $error("start-up timer finished at wrong count");

endmodule : scss_startup

// *** core/scss_top.sv ***
`timescale 1ns/1ps
`include "scss_map.svh"

module scss_top #(
	parameter int AW = 8
) (
	input  wire logic          aclk,                     // 25 MHz system clock
	input  wire logic          aresetn,                  // sync reset, active low
	input  wire logic [AW-1:0] s_axi_awaddr,             // write address
	input  wire logic          s_axi_awvalid,            // write address valid
	output logic               s_axi_awready,            // write address ready
	input  wire logic [31:0]   s_axi_wdata,              // write data
	input  wire logic [3:0]    s_axi_wstrb,              // write byte strobes
	input  wire logic          s_axi_wvalid,             // write data valid
	output logic               s_axi_wready,             // write data ready
	output logic [1:0]         s_axi_bresp,              // write response
	output logic               s_axi_bvalid,             // write response valid
	input  wire logic          s_axi_bready,             // write response ready
	input  wire logic [AW-1:0] s_axi_araddr,             // read address
	input  wire logic          s_axi_arvalid,            // read address valid
	output logic               s_axi_arready,            // read address ready
	output logic [31:0]        s_axi_rdata,              // read data
	output logic [1:0]         s_axi_rresp,              // read response
	output logic               s_axi_rvalid,             // read data valid
	input  wire logic          s_axi_rready,             // read data ready
	input  wire logic [2:0]    clock_source_config,      // non-volatile source code
	input  wire logic          clock_out_pin_enable,     // 1: pin drives clock out
	input  wire logic          first_osc_pin,            // external source level
	input  wire logic          secondary_crystal_in_pin, // secondary osc level
	input  wire logic          hf_int_osc,               // 16 MHz internal level
	input  wire logic          low_freq_internal_osc,    // 31 kHz internal level
	input  wire logic          wake_pulse,               // pulse: wake from sleep
	input  wire logic          gpio_out,                 // port value for pin
	input  wire logic          gpio_oe,                  // port enable for pin
	output logic               sys_clk,                  // system clock level
	output logic               second_osc_pin_out,       // pin output value
	output logic               second_osc_pin_oe,        // pin output enable
	output logic [1:0]         amp_gain,                 // crystal amplifier gain
	output logic [1:0]         logic_clk_power,          // external clock power range
	output logic               startup_timer_running     // start-up wait in progress
);

	initial begin
		if (AW < 3)
			$error("scss_top: AW too narrow for register map");
	end

	typedef struct packed {
		scss_pkg::scss_sw_t  sw;
		scss_pkg::scss_src_t cur;
		scss_pkg::scss_src_t tgt;
		logic [2:0]          cfg;
		logic [1:0]          sel;
		logic                lf;
		logic                stw_go;
		logic                clk;
		logic                pin_out;
		logic                pin_oe;
		logic [1:0]          gain;
		logic [1:0]          pwr;
		logic                ostr;
		logic                awr;
		logic                bv;
		logic [1:0]          br;
		logic                arr;
		logic                rv;
		logic [1:0]          rr;
		logic [31:0]         rd;
	} scss_st_t;

	scss_st_t st_r;
	scss_st_t st_nxt;
	logic     stw_ready;

	////////////////////////////////////////////////////////////////////////////
	// decode helpers

	// source wanted for a select code
	function automatic scss_pkg::scss_src_t want_src(input logic [1:0] sel, input logic lf,
			input logic [2:0] cfg);
		if (sel == `SCSS_SEL_CONFIG)
			want_src = (cfg == `SCSS_CFG_INTOSC) ? scss_pkg::SRC_HF : scss_pkg::SRC_EXT;
		else if (sel == `SCSS_SEL_SECOND)
			want_src = scss_pkg::SRC_SOSC;
		else
			want_src = lf ? scss_pkg::SRC_LF : scss_pkg::SRC_HF;
	endfunction : want_src

	// level of a given source right now
	function automatic logic src_lvl(input scss_pkg::scss_src_t s, input logic ext, input logic sosc,
			input logic hf, input logic lfo);
		unique case (s)
			scss_pkg::SRC_EXT:  src_lvl = ext;
			scss_pkg::SRC_SOSC: src_lvl = sosc;
			scss_pkg::SRC_HF:   src_lvl = hf;
			scss_pkg::SRC_LF:   src_lvl = lfo;
		endcase
	endfunction : src_lvl

	function automatic logic is_crystal(input logic [2:0] cfg);
		is_crystal = (cfg == `SCSS_CFG_XTAL_LO) || (cfg == `SCSS_CFG_XTAL_MID) || (cfg == `SCSS_CFG_XTAL_HI);
	endfunction : is_crystal

	logic cur_lvl;
	logic tgt_lvl;
	logic stw_bypass;
	assign cur_lvl    = src_lvl(st_r.cur, first_osc_pin, secondary_crystal_in_pin, hf_int_osc,
		low_freq_internal_osc);
	assign tgt_lvl    = src_lvl(st_r.tgt, first_osc_pin, secondary_crystal_in_pin, hf_int_osc,
		low_freq_internal_osc);
	// only a crystal needs settling time; logic clock, rc and internal start at once
	assign stw_bypass = !is_crystal(st_r.cfg);

	scss_startup u_scss_startup (
		.aclk    (aclk),
		.aresetn (aresetn),
		.osc_lvl (first_osc_pin),
		.restart (st_r.stw_go),
		.bypass  (stw_bypass),
		.ready   (stw_ready)
	);

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		scss_pkg::scss_src_t w;
		logic                wr_go;
		logic                rd_go;
		logic                ext_ok;
		w      = want_src(st_r.sel, st_r.lf, st_r.cfg);
		wr_go  = 1'b0;
		rd_go  = 1'b0;
		ext_ok = 1'b0;
		st_nxt = st_r;
		st_nxt.stw_go = 1'b0;

		// switch sequencer: stop old source only while low, start new one from low
		unique case (st_r.sw)
			scss_pkg::SW_BOOT: begin
				st_nxt.cfg    = clock_source_config;
				st_nxt.tgt    = want_src(st_r.sel, st_r.lf, clock_source_config);
				st_nxt.cur    = st_nxt.tgt;
				st_nxt.stw_go = 1'b1;
				st_nxt.sw     = scss_pkg::SW_WAIT;
			end
			scss_pkg::SW_RUN: begin
				// a stalled source just freezes the output; nothing is reset
				st_nxt.clk = cur_lvl;
				if (w != st_r.cur) begin
					st_nxt.tgt = w;
					st_nxt.sw  = scss_pkg::SW_PARK;
				end else if (wake_pulse && st_r.cur == scss_pkg::SRC_EXT && is_crystal(st_r.cfg)) begin
					st_nxt.tgt = st_r.cur;
					st_nxt.sw  = scss_pkg::SW_PARK;
				end
			end
			scss_pkg::SW_PARK: begin
				st_nxt.clk = cur_lvl;
				if (!cur_lvl) begin
					st_nxt.clk    = 1'b0;
					st_nxt.stw_go = (st_r.tgt == scss_pkg::SRC_EXT);
					st_nxt.sw     = scss_pkg::SW_WAIT;
				end
			end
			scss_pkg::SW_WAIT: begin
				st_nxt.clk = 1'b0;
				ext_ok     = (st_r.tgt != scss_pkg::SRC_EXT) || (stw_ready && !st_r.stw_go);
				if (ext_ok && !tgt_lvl) begin
					st_nxt.cur = st_r.tgt;
					st_nxt.sw  = scss_pkg::SW_RUN;
				end
			end
		endcase
		// judged on the config being loaded, so the boot cycle already knows the mode
		st_nxt.ostr = (st_nxt.sw == scss_pkg::SW_WAIT) && (st_nxt.tgt == scss_pkg::SRC_EXT) && is_crystal(st_nxt.cfg);

		// gain follows crystal mode, power range follows logic clock code
		unique case (st_nxt.cfg)
			`SCSS_CFG_XTAL_LO:  st_nxt.gain = `SCSS_LVL_LOW;
			`SCSS_CFG_XTAL_MID: st_nxt.gain = `SCSS_LVL_MED;
			`SCSS_CFG_XTAL_HI:  st_nxt.gain = `SCSS_LVL_HIGH;
			default:           st_nxt.gain = `SCSS_LVL_OFF;
		endcase
		unique case (st_nxt.cfg)
			`SCSS_CFG_LOGIC_HIGH: st_nxt.pwr = `SCSS_LVL_HIGH;
			`SCSS_CFG_LOGIC_MED:  st_nxt.pwr = `SCSS_LVL_MED;
			`SCSS_CFG_LOGIC_LOW:  st_nxt.pwr = `SCSS_LVL_LOW;
			default:           st_nxt.pwr = `SCSS_LVL_OFF;
		endcase

		// second pin: crystal owns it, otherwise clock out or gpio
		if (is_crystal(st_nxt.cfg)) begin
			st_nxt.pin_out = 1'b0;
			st_nxt.pin_oe  = 1'b0;
		end else if (clock_out_pin_enable) begin
			st_nxt.pin_out = st_nxt.clk;
			st_nxt.pin_oe  = 1'b1;
		end else begin
			st_nxt.pin_out = gpio_out;
			st_nxt.pin_oe  = gpio_oe;
		end

		// axi write: both channels taken in one beat, response after
		if (st_r.awr) begin
			st_nxt.awr = 1'b0;
			wr_go      = 1'b1;
		end else if (s_axi_awvalid && s_axi_wvalid && !st_r.bv) begin
			st_nxt.awr = 1'b1;
		end
		if (wr_go) begin
			st_nxt.bv = 1'b1;
			st_nxt.br = `SCSS_RESP_SLVERR;
			if (s_axi_awaddr == AW'(`SCSS_OFS_CTRL)) begin
				st_nxt.br = `SCSS_RESP_OKAY;
				if (s_axi_wstrb[0]) begin
					st_nxt.sel = s_axi_wdata[`SCSS_CTRL_SEL_MSB:`SCSS_CTRL_SEL_LSB];
					st_nxt.lf  = s_axi_wdata[`SCSS_CTRL_LF_BIT];
				end
			end else if (s_axi_awaddr == AW'(`SCSS_OFS_STATUS)) begin
				st_nxt.br = `SCSS_RESP_OKAY;
			end
		end else if (st_r.bv && s_axi_bready) begin
			st_nxt.bv = 1'b0;
		end

		// axi read
		if (st_r.arr) begin
			st_nxt.arr = 1'b0;
			rd_go      = 1'b1;
		end else if (s_axi_arvalid && !st_r.rv) begin
			st_nxt.arr = 1'b1;
		end
		if (rd_go) begin
			st_nxt.rv = 1'b1;
			st_nxt.rd = '0;
			st_nxt.rr = `SCSS_RESP_OKAY;
			if (s_axi_araddr == AW'(`SCSS_OFS_CTRL)) begin
				st_nxt.rd[`SCSS_CTRL_SEL_MSB:`SCSS_CTRL_SEL_LSB] = st_r.sel;
				st_nxt.rd[`SCSS_CTRL_LF_BIT]                     = st_r.lf;
			end else if (s_axi_araddr == AW'(`SCSS_OFS_STATUS)) begin
				st_nxt.rd[`SCSS_ST_SRC_MSB:`SCSS_ST_SRC_LSB]   = st_r.cur;
				st_nxt.rd[`SCSS_ST_BUSY_BIT]                   = (st_r.sw != scss_pkg::SW_RUN) || (w != st_r.cur);
				st_nxt.rd[`SCSS_ST_STW_BIT]                    = st_r.ostr;
				st_nxt.rd[`SCSS_ST_GAIN_MSB:`SCSS_ST_GAIN_LSB] = st_r.gain;
				st_nxt.rd[`SCSS_ST_PWR_MSB:`SCSS_ST_PWR_LSB]   = st_r.pwr;
				st_nxt.rd[`SCSS_ST_CKO_BIT]                    = st_r.pin_oe && !is_crystal(st_r.cfg);
				st_nxt.rd[`SCSS_ST_CFG_MSB:`SCSS_ST_CFG_LSB]   = st_r.cfg;
			end else begin
				st_nxt.rr = `SCSS_RESP_SLVERR;
			end
		end else if (st_r.rv && s_axi_rready) begin
			st_nxt.rv = 1'b0;
		end
	end

	// config is loaded from the pins in the first cycle after reset, not in reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r                <= '0;
			st_r.sw             <= scss_pkg::SW_BOOT;
			{st_r.lf, st_r.sel} <= `SCSS_CTRL_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign s_axi_awready      = st_r.awr;
	assign s_axi_wready       = st_r.awr;
	assign s_axi_bvalid       = st_r.bv;
	assign s_axi_bresp        = st_r.br;
	assign s_axi_arready      = st_r.arr;
	assign s_axi_rvalid       = st_r.rv;
	assign s_axi_rresp        = st_r.rr;
	assign s_axi_rdata        = st_r.rd;
	assign sys_clk            = st_r.clk;
	assign second_osc_pin_out = st_r.pin_out;
	assign second_osc_pin_oe  = st_r.pin_oe;
	assign amp_gain           = st_r.gain;
	assign logic_clk_power    = st_r.pwr;
	assign startup_timer_running = st_r.ostr;

	////////////////////////////////////////////////////////////////////////////
	// checks

	a_boot_source: assert property (@(posedge aclk) disable iff (!aresetn)
		st_r.sw == scss_pkg::SW_BOOT && aresetn |=> st_r.cfg == $past(clock_source_config))
		else $error("boot did not load configured source");

	a_select_switch: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_r.sw == scss_pkg::SW_RUN && want_src(st_r.sel, st_r.lf, st_r.cfg) != st_r.cur)
		|=> st_r.sw == scss_pkg::SW_PARK)
		else $error("select change did not start a switch");

	a_internal_pick: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_r.sw == scss_pkg::SW_RUN && st_r.sel[1] && st_r.cur != (st_r.lf ? scss_pkg::SRC_LF : scss_pkg::SRC_HF))
		|=> st_r.tgt == ($past(st_r.lf) ? scss_pkg::SRC_LF : scss_pkg::SRC_HF))
		else $error("internal select targeted wrong oscillator");

	a_logic_range: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_r.sw != scss_pkg::SW_BOOT && st_r.cfg == `SCSS_CFG_LOGIC_HIGH) |-> st_r.pwr == `SCSS_LVL_HIGH)
		else $error("external clock power range wrong");

	a_logic_no_wait: assert property (@(posedge aclk) disable iff (!aresetn)
		st_r.cfg[2] && st_r.cfg != `SCSS_CFG_INTOSC |-> !st_r.ostr)
		else $error("start-up timer ran in logic clock mode");

	a_halt_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_r.sw == scss_pkg::SW_RUN && $stable(cur_lvl) && $past(st_r.sw) == scss_pkg::SW_RUN
		&& $past(st_r.cur) == st_r.cur) |=> $stable(st_r.clk) || st_r.sw != scss_pkg::SW_RUN)
		else $error("clock moved while its source stood still");

	a_pin_clkout: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_r.sw != scss_pkg::SW_BOOT && !is_crystal(st_r.cfg) && clock_out_pin_enable)
		|=> second_osc_pin_oe && second_osc_pin_out == sys_clk)
		else $error("clock out pin not driving clock");

	a_xtal_gain: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_r.sw != scss_pkg::SW_BOOT && st_r.cfg == `SCSS_CFG_XTAL_LO) |-> st_r.gain == `SCSS_LVL_LOW)
		else $error("crystal gain wrong");

	a_no_runt: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_r.sw == scss_pkg::SW_WAIT) |-> !st_r.clk)
		else $error("clock high during source handover");

	c_switch_done: cover property (@(posedge aclk) disable iff (!aresetn)
		st_r.sw == scss_pkg::SW_WAIT ##1 st_r.sw == scss_pkg::SW_RUN);
	c_to_lf: cover property (@(posedge aclk) disable iff (!aresetn) st_r.cur == scss_pkg::SRC_LF);
	c_startup_wait: cover property (@(posedge aclk) disable iff (!aresetn) $fell(st_r.ostr));
	c_bad_read: cover property (@(posedge aclk) disable iff (!aresetn)
		st_r.rv && st_r.rr == `SCSS_RESP_SLVERR);

endmodule : scss_top

// *** testbench/scss_src_model.sv ***
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// clock source stand-ins: levels move on aclk edges because the block samples
// them as synchronous levels; rates are scaled well below aclk for that reason
module scss_src_model #(
	parameter int EXT_HALF  = 3, // external clock half period, cycles
	parameter int SOSC_HALF = 4, // secondary crystal half period, cycles
	parameter int HF_HALF   = 2, // fast internal oscillator half period
	parameter int LF_HALF   = 6  // slow internal oscillator half period
) (
	input  wire logic aclk,     // bench clock
	input  wire logic ext_run,  // 0 stops the external clock where it stands
	output logic      ext_lvl,  // external logic clock level
	output logic      sosc_lvl, // secondary crystal level
	output logic      hf_lvl,   // fast internal level
	output logic      lf_lvl    // slow internal level
);
	localparam int HALF [4] = '{EXT_HALF, SOSC_HALF, HF_HALF, LF_HALF};
	int         cnt [4] = '{0, 0, 0, 0};
	logic [3:0] lvl     = 4'h0;

	// a stopped external clock holds its level, as a real oscillator module would
	always @(posedge aclk) begin
		for (int i = 0; i < 4; i++) begin
			if (i != 0 || ext_run) begin
				if (cnt[i] >= HALF[i] - 1) begin
					cnt[i] <= 0;
					lvl[i] <= ~lvl[i];
				end else begin
					cnt[i] <= cnt[i] + 1;
				end
			end
		end
	end

	// level outputs
	assign ext_lvl  = lvl[0];
	assign sosc_lvl = lvl[1];
	assign hf_lvl   = lvl[2];
	assign lf_lvl   = lvl[3];
endmodule : scss_src_model

// *** testbench/scss_top_test.sv ***
`timescale 1ns/1ps
`include "scss_map.svh"

`define SCSS_TB_CHK(nm, ex, got) \
	begin \
		samples_checked++; \
		if ((got) !== (ex)) begin \
			miscompares++; \
			$display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); \
		end \
	end

module scss_top_test;
	logic        aclk = 1'h0;
	logic        aresetn = 1'h0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb = 4'h0;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, ext_run = 1'h1, lv;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, amp_gain, logic_clk_power, r;
	logic [2:0]  clock_source_config = 3'h0;
	logic        clock_out_pin_enable = 1'h0, wake_pulse = 1'h0, gpio_out = 1'h0, gpio_oe = 1'h0;
	logic        first_osc_pin, secondary_crystal_in_pin, hf_int_osc, low_freq_internal_osc;
	logic        sys_clk, second_osc_pin_out, second_osc_pin_oe, startup_timer_running;
	int          miscompares = 0, samples_checked = 0, hi = 0;
	bit          watch_runt = 1'h0;
	int unsigned sel_tab [4] = '{32'h1, 32'h2, 32'h6, 32'h0};
	int          src_tab [4] = '{1, 2, 3, 0};

	scss_top u_scss_top (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.clock_source_config, .clock_out_pin_enable, .first_osc_pin, .secondary_crystal_in_pin,
		.hf_int_osc, .low_freq_internal_osc, .wake_pulse, .gpio_out, .gpio_oe, .sys_clk,
		.second_osc_pin_out, .second_osc_pin_oe, .amp_gain, .logic_clk_power, .startup_timer_running
	);

	scss_src_model u_scss_src_model (
		.aclk, .ext_run, .ext_lvl(first_osc_pin), .sosc_lvl(secondary_crystal_in_pin),
		.hf_lvl(hf_int_osc), .lf_lvl(low_freq_internal_osc)
	);

	////////////////////////////////////////////////////////////////////////////
	// 25 MHz clock
	initial begin
		forever #20 aclk = ~aclk;
	end

	// a truncated high pulse shows as one cycle; every source stays high two or more
	always @(posedge aclk) begin
		if (sys_clk === 1'h1) begin
			hi <= hi + 1;
		end else begin
			if (watch_runt && hi > 0) `SCSS_TB_CHK("sys_clk_high_width", 1, hi >= 2)
			hi <= 0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// reference model of the decoders
	function automatic int exp_gain(input int c);
		return (c < 3) ? c + 1 : 0;
	endfunction : exp_gain

	function automatic int exp_pwr(input int c);
		return (c > 4) ? c - 4 : 0;
	endfunction : exp_pwr

	function automatic logic src_lvl(input int s);
		return (s == 0) ? first_osc_pin : (s == 1) ? secondary_crystal_in_pin : (s == 2) ? hf_int_osc
			: low_freq_internal_osc;
	endfunction : src_lvl

	////////////////////////////////////////////////////////////////////////////
	// bus master; starts one edge late so a lowered strobe is never raised in the same step
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] wd, input logic [3:0] s, output logic [1:0] rs);
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= wd;
		s_axi_wstrb   <= s;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid  <= 1'h1;
		s_axi_bready  <= 1'h1;
		do @(posedge aclk); while (s_axi_awready !== 1'h1);
		s_axi_awvalid <= 1'h0;
		s_axi_wvalid  <= 1'h0;
		while (s_axi_bvalid !== 1'h1) @(posedge aclk);
		rs = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] rs);
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready  <= 1'h1;
		do @(posedge aclk); while (s_axi_arready !== 1'h1);
		s_axi_arvalid <= 1'h0;
		while (s_axi_rvalid !== 1'h1) @(posedge aclk);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask : axi_rd

	// status is polled only after the switch has had time to start
	task automatic wait_idle(output logic [31:0] sd);
		logic [1:0] rs;
		repeat (4) @(posedge aclk);
		do axi_rd(`SCSS_OFS_STATUS, sd, rs); while (sd[`SCSS_ST_BUSY_BIT] !== 1'h0);
	endtask : wait_idle

	task automatic do_reset(input logic [2:0] c);
		@(posedge aclk);
		aresetn             <= 1'h0;
		clock_source_config <= c;
		repeat (12) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (8) @(posedge aclk);
	endtask : do_reset

	// sys_clk must equal the chosen source one cycle later
	task automatic follow_check(input int s, input int n);
		logic l;
		@(posedge aclk);
		#1;
		repeat (n) begin
			l = src_lvl(s);
			@(posedge aclk);
			#1;
			`SCSS_TB_CHK("sys_clk_follow", l, sys_clk)
		end
	endtask : follow_check

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : close_out

	////////////////////////////////////////////////////////////////////////////
	// a hang is cut off well past the seven thousand or so cycles the tests need
	initial begin
		repeat (60000) @(posedge aclk);
		miscompares++;
		close_out();
	end

	initial begin
		void'($urandom(45));
		do_reset(3'h7);
		// register access, refusals and strobes
		axi_rd(`SCSS_OFS_CTRL, d, r);
		`SCSS_TB_CHK("ctrl_reset", 0, d)
		axi_rd(8'h08, d, r);
		`SCSS_TB_CHK("unmapped_rresp", 2, r)
		`SCSS_TB_CHK("unmapped_rdata", 0, d)
		axi_wr(8'h08, 32'h5, 4'hf, r);
		`SCSS_TB_CHK("unmapped_bresp", 2, r)
		axi_wr(`SCSS_OFS_STATUS, 32'hfff, 4'hf, r);
		`SCSS_TB_CHK("status_bresp", 0, r)
		axi_wr(`SCSS_OFS_CTRL, 32'h5, 4'h0, r);
		axi_rd(`SCSS_OFS_CTRL, d, r);
		`SCSS_TB_CHK("ctrl_no_strobe", 0, d)
		$display("test registers done");
		// every configuration code after reset, pin function and wake
		for (int c = 0; c < 8; c++) begin
			clock_out_pin_enable <= 1'($urandom);
			gpio_out             <= 1'($urandom);
			gpio_oe              <= 1'($urandom);
			do_reset(3'(c));
			`SCSS_TB_CHK("amp_gain", exp_gain(c), amp_gain)
			`SCSS_TB_CHK("logic_clk_power", exp_pwr(c), logic_clk_power)
			`SCSS_TB_CHK("startup_timer_running", c < 3, startup_timer_running)
			axi_rd(`SCSS_OFS_STATUS, d, r);
			`SCSS_TB_CHK("boot_src", (c == 4) ? 2 : 0, d[1:0])
			`SCSS_TB_CHK("boot_cfg", c, d[`SCSS_ST_CFG_MSB:`SCSS_ST_CFG_LSB])
			ext_run <= 1'h0;
			repeat (6) @(posedge aclk);
			if (c < 3) begin
				`SCSS_TB_CHK("pin_oe", 0, second_osc_pin_oe)
				`SCSS_TB_CHK("pin_out", 0, second_osc_pin_out)
			end else if (c != 4) begin
				lv = clock_out_pin_enable ? first_osc_pin : gpio_out;
				`SCSS_TB_CHK("pin_oe", clock_out_pin_enable | gpio_oe, second_osc_pin_oe)
				`SCSS_TB_CHK("pin_out", lv, second_osc_pin_out)
			end
			ext_run    <= 1'h1;
			wake_pulse <= 1'h1;
			@(posedge aclk);
			wake_pulse <= 1'h0;
			repeat (3) @(posedge aclk);
			`SCSS_TB_CHK("startup_after_wake", c < 3, startup_timer_running)
		end
		$display("test boot done");
		// a crystal boot waits out the start-up count (six cycles per model period), a wake restarts it
		do_reset(3'h1);
		repeat (`SCSS_STARTUP_EDGES * 6 - 150) @(posedge aclk);
		`SCSS_TB_CHK("startup_mid", 1, startup_timer_running)
		repeat (300) @(posedge aclk);
		`SCSS_TB_CHK("startup_end", 0, startup_timer_running)
		wake_pulse <= 1'h1;
		@(posedge aclk);
		wake_pulse <= 1'h0;
		repeat (6) @(posedge aclk);
		`SCSS_TB_CHK("startup_rewake", 1, startup_timer_running)
		$display("test startup done");
		// run-time switching, back to back first, then every source in turn
		do_reset(3'h7);
		watch_runt = 1'h1;
		follow_check(0, 12);
		axi_wr(`SCSS_OFS_CTRL, 32'h1, 4'hf, r);
		axi_wr(`SCSS_OFS_CTRL, 32'h6, 4'hf, r);
		wait_idle(d);
		`SCSS_TB_CHK("reselect_src", 3, d[1:0])
		for (int i = 0; i < 4; i++) begin
			axi_wr(`SCSS_OFS_CTRL, sel_tab[i], 4'hf, r);
			axi_rd(`SCSS_OFS_CTRL, d, r);
			`SCSS_TB_CHK("ctrl_readback", sel_tab[i], d[2:0])
			wait_idle(d);
			`SCSS_TB_CHK("switch_src", src_tab[i], d[1:0])
			follow_check(src_tab[i], 30);
		end
		$display("test switching done");
		// a stopped external clock freezes sys_clk, which resumes on restart
		ext_run <= 1'h0;
		repeat (3) @(posedge aclk);
		lv = sys_clk;
		repeat (25) @(posedge aclk);
		`SCSS_TB_CHK("halt_level", lv, sys_clk)
		`SCSS_TB_CHK("halt_matches_src", first_osc_pin, sys_clk)
		ext_run <= 1'h1;
		follow_check(0, 20);
		$display("test halt done");
		close_out();
	end
endmodule : scss_top_test
